// ===== dv/fperl_core_assertions.sv
// port checks of the floating-point exception logic
`timescale 1ns/1ps
`default_nettype none
module fperl_core_assertions
  import fperl_pkg::*;
(
  input wire logic           sys_clk_in,
  input wire logic           rst_n_in,
  input wire logic           avs_read_in,
  input wire logic           avs_write_in,
  input wire logic           avs_waitrequest_out,
  input wire fperl_req_type  req_in,
  input wire fperl_resp_type resp_out,
  input wire logic [1:0]     rounding_mode_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_lat;
    req_in.valid |=> resp_out.valid;
  endproperty
  a_lat: assert property (p_lat) else $error("no response");
  property p_trap_nw;
    resp_out.valid && resp_out.trap |-> !resp_out.dest_write;
  endproperty
  a_trap_nw: assert property (p_trap_nw) else $error("trap wrote dest");
  property p_onehot;
    resp_out.trap |-> $onehot(resp_out.cexc);
  endproperty
  a_onehot: assert property (p_onehot) else $error("trap cexc not one-hot");
  property p_wide;
    req_in.valid && req_in.op inside {FPERL_OP_SMUL_D, FPERL_OP_DMUL_Q}
      |=> resp_out.cexc[3:2] == 2'h0 && !resp_out.cexc[0];
  endproperty
  a_wide: assert property (p_wide) else $error("widening flags");
  property p_uf_nx;
    req_in.valid && req_in.op == FPERL_OP_ADD && req_in.core_tiny && req_in.core_inexact
      |=> resp_out.trap || resp_out.cexc[2];
  endproperty
  a_uf_nx: assert property (p_uf_nx) else $error("underflow missing");
  property p_tiny;
    req_in.valid && req_in.op == FPERL_OP_ADD && !req_in.core_tiny |=> !resp_out.cexc[2];
  endproperty
  a_tiny: assert property (p_tiny) else $error("underflow without tiny");
  property p_i32;
    req_in.valid && req_in.op == FPERL_OP_TO_I32 && req_in.fmt == FPERL_FMT_D
      && req_in.src2[62:52] == 11'h7ff |=> resp_out.cexc[4];
  endproperty
  a_i32: assert property (p_i32) else $error("invalid missing");
  property p_zero;
    req_in.valid && req_in.op == FPERL_OP_SUB && req_in.fmt == FPERL_FMT_D && req_in.core_exact_zero
      && rounding_mode_out == 2'h0 |=> resp_out.result[63:0] == 64'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero sign");
  property p_wait;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_wait: assert property (p_wait) else $error("wait too long");
endmodule
bind fperl_core fperl_core_assertions u_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
  .req_in(req_in), .resp_out(resp_out), .rounding_mode_out(rounding_mode_out));
`default_nettype wire

// ===== dv/fperl_pipe_model.sv
// pipeline-side model: destination register written only by completing operations
`timescale 1ns/1ps
`default_nettype none
module fperl_pipe_model
  import fperl_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           rst_n_in,
  input  wire fperl_resp_type resp_in,
  output logic [63:0]         freg_out
);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      freg_out <= '0;
    end else if (resp_in.valid && resp_in.dest_write) begin
      freg_out <= resp_in.result[63:0];
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// testbench of the floating-point exception logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fperl_pkg::*;
  localparam logic [63:0] one = 64'h3ff0_0000_0000_0000;
  localparam logic [63:0] inf = 64'h7ff0_0000_0000_0000;
  logic           clk = 0, rst_n = 0, rd = 0, wr = 0, he = 0, wq;
  logic [3:0]     ad = '0, be = '0;
  logic [31:0]    wd = '0, rdat, q;
  logic [1:0]     rm;
  logic [63:0]    fr, pv;
  fperl_req_type  r = '0;
  fperl_resp_type s;
  int             err_count = 0, total_checks = 0;
  always #5 clk = ~clk;
  fperl_core dut (.sys_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(ad), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wq), .req_in(r), .handler_entry_in(he), .resp_out(s), .rounding_mode_out(rm));
  fperl_pipe_model pm (.clk_in(clk), .rst_n_in(rst_n), .resp_in(s), .freg_out(fr));
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    be <= b;
    do @(posedge clk); while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, '0, 4'hf);
    chk("register", e, q);
  endtask
  task automatic go(input fperl_op_type o, input logic [63:0] a, input logic [63:0] b, input logic [3:0] f,
                    input logic [63:0] e, input logic [4:0] c, input logic t);
    @(posedge clk);
    r.valid <= 1'b1;
    r.op <= o;
    r.fmt <= FPERL_FMT_D;
    r.src1 <= a;
    r.src2 <= b;
    {r.core_tiny, r.core_inexact, r.core_overflow, r.core_exact_zero} <= f;
    @(posedge clk);
    r.valid <= 1'b0;
    r.src1 <= ~a;
    r.src2 <= ~b;
    @(negedge clk);
    chk("valid", 64'h1, s.valid);
    chk("cexc", c, s.cexc);
    chk("trap", t, s.trap);
    if (o != FPERL_OP_CMP && !t) begin
      chk("result", e, s.result[63:0]);
    end
    if (o != FPERL_OP_CMP) begin
      chk("dest_write", !t, s.dest_write);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdc(4'h0, 32'h0000_0000);
    rdc(4'hc, 32'h0000_0000);
    go(FPERL_OP_CMP, 64'h4000_0000_0000_0000, one, 4'h0, '0, 5'h00, 1'b0);
    go(FPERL_OP_ADD, one, one, 4'hc, '0, 5'h05, 1'b0);
    bus(1'b1, 4'h0, 32'h0840_0000, 4'hc);
    pv = fr;
    go(FPERL_OP_TO_I32, one, 64'h7ff8_0000_0000_0000, 4'h0, '0, 5'h10, 1'b1);
    // the pipeline model takes the response one edge later
    @(negedge clk);
    chk("fp_register", pv, fr);
    rdc(4'h0, 32'h0840_48b0);
    @(posedge clk);
    he <= 1'b1;
    @(posedge clk);
    he <= 1'b0;
    rdc(4'h0, 32'h0840_08b0);
    bus(1'b1, 4'h0, 32'h0040_0000, 4'hc);
    go(FPERL_OP_MUL, 64'h7ff0_0000_0000_0001, 64'h7ff8_0000_0000_0002, 4'h0,
       64'h7ff8_0000_0000_0001, 5'h10, 1'b0);
    go(FPERL_OP_SUB, inf, inf, 4'h0, 64'h7fff_ffff_ffff_ffff, 5'h10, 1'b0);
    go(FPERL_OP_TO_I32, one, 64'hfff0_0000_0000_0000, 4'h0, 64'h8000_0000, 5'h10, 1'b0);
    go(FPERL_OP_TO_I32, one, 64'h41e0_0000_0000_0000, 4'h0, 64'h7fff_ffff, 5'h10, 1'b0);
    go(FPERL_OP_TO_I32, one, 64'hc1e0_0000_0000_0000, 4'h0, 64'h8000_0000, 5'h00, 1'b0);
    go(FPERL_OP_TO_I64, one, 64'hfff8_0000_0000_0000, 4'h0, 64'h8000_0000_0000_0000, 5'h10, 1'b0);
    go(FPERL_OP_TO_I64, one, 64'h43e0_0000_0000_0000, 4'h0, 64'h7fff_ffff_ffff_ffff, 5'h10, 1'b0);
    go(FPERL_OP_SMUL_D, 64'h7fc0_0001, 64'h3f80_0000, 4'he, 64'h7ff8_0000_2000_0000, 5'h00, 1'b0);
    go(FPERL_OP_SUB, one, one, 4'h1, 64'h0000_0000_0000_0000, 5'h00, 1'b0);
    bus(1'b1, 4'h0, 32'hc240_0000, 4'hc);
    go(FPERL_OP_SUB, one, one, 4'h1, 64'h8000_0000_0000_0000, 5'h00, 1'b0);
    chk("rounding_mode", 64'h3, rm);
    go(FPERL_OP_TO_I32, one, 64'hc006_0000_0000_0000, 4'h4, 64'hffff_fffe, 5'h01, 1'b0);
    go(FPERL_OP_ADD, one, one, 4'h8, '0, 5'h04, 1'b1);
    go(FPERL_OP_ADD, one, one, 4'h4, '0, 5'h01, 1'b0);
    rdc(4'h8, 32'h0000_0002);
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== verilog/fperl_cfg.svh
// register offsets, field positions and codes of the floating-point exception logic
`ifndef FPERL_CFG_SVH
`define FPERL_CFG_SVH

// register byte offsets
`define FPERL_OFS_STATE     4'h0
`define FPERL_OFS_COND      4'h4
`define FPERL_OFS_TRAPS     4'h8

// fp_state_reg word layout
`define FPERL_RD_LSB        30
`define FPERL_TEM_LSB       23
`define FPERL_RELAX_BIT     22
`define FPERL_FTT_LSB       14
`define FPERL_QNE_BIT       13
`define FPERL_COND0_LSB     10
`define FPERL_AEXC_LSB      5
`define FPERL_CEXC_LSB      0
`define FPERL_COND_W        2
`define FPERL_EXC_W         5

// exception bit positions inside the five-bit exception fields
`define FPERL_EXC_BAD       4
`define FPERL_EXC_OVF       3
`define FPERL_EXC_UNF       2
`define FPERL_EXC_DZ        1
`define FPERL_EXC_INX       0

// trap type codes and rounding modes
`define FPERL_FTT_NONE      3'h0
`define FPERL_FTT_IEEE      3'h1
`define FPERL_RD_NEAREST    2'h0
`define FPERL_RD_MINUS      2'h3

// compare results
`define FPERL_CMP_EQ        2'h0
`define FPERL_CMP_LT        2'h1
`define FPERL_CMP_GT        2'h2
`define FPERL_CMP_UN        2'h3

// exponent constants
`define FPERL_EXP_BIAS      12'h3ff
`define FPERL_SGL_REBIAS    11'h380
`define FPERL_SGL_EXP_MAX   8'hff
`define FPERL_DBL_EXP_MAX   11'h7ff
`define FPERL_I64_TOP       6'h3f

// saturated integer results
`define FPERL_I32_MAX       32'h7fff_ffff
`define FPERL_I32_MIN       32'h8000_0000
`define FPERL_I64_MAX       64'h7fff_ffff_ffff_ffff
`define FPERL_I64_MIN       64'h8000_0000_0000_0000

`endif

// ===== verilog/fperl_core.sv
// floating-point exception, special-result and trap logic with its state register
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fperl_cfg.svh"
module fperl_core
  import fperl_pkg::*;
(
  input  wire logic          sys_clk_in,
  input  wire logic          rst_n_in,
  input  wire logic [3:0]    avs_address_in,
  input  wire logic          avs_read_in,
  input  wire logic          avs_write_in,
  input  wire logic [31:0]   avs_writedata_in,
  input  wire logic [3:0]    avs_byteenable_in,
  output logic [31:0]        avs_readdata_out,
  output logic               avs_waitrequest_out,
  input  wire fperl_req_type req_in,
  input  wire logic          handler_entry_in,
  output var fperl_resp_type resp_out,
  output logic [1:0]         rounding_mode_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [1:0]       round_mode;
  logic [4:0]       trap_mask;
  logic             relaxed_ieee_bit;
  logic [2:0]       trap_kind;
  logic [4:0]       accrued;
  logic [4:0]       current;
  logic [3:0][1:0]  fp_cond_codes;
  logic [15:0]      trap_count;
  logic             bus_ack;

  fperl_opnd_type   a;
  fperl_opnd_type   b;
  logic             opnd_dbl;
  fperl_fmt_type    rfmt;

  logic [4:0]       exc;
  logic [127:0]     res;
  logic             dest_wr;
  logic             cond_wr;
  logic [1:0]       cond_val;
  logic [4:0]       enabled;
  logic [4:0]       trap_pick;
  logic             trap;
  logic             fire;
  logic             eff_sub;

  logic [11:0]      ue;
  logic [63:0]      sig;
  logic [127:0]     wide;
  logic [63:0]      trunc;
  logic [63:0]      neg;
  logic             lost;
  logic             big;
  logic             inv32;
  logic             inv64;

  logic [31:0]      state_word;
  logic [31:0]      cond_word;
  logic [31:0]      be_mask;
  logic [31:0]      wr_state;
  logic [31:0]      wr_cond;
  logic             sw_wr_state;
  logic             sw_wr_cond;

  assign fire              = req_in.valid;
  assign rounding_mode_out = round_mode;

  ////////////////////////////////////////////////////////////////////////////
  // operand unpacking

  always_comb begin
    case (req_in.op)
      FPERL_OP_SMUL_D: begin
        opnd_dbl = 1'b0;
        rfmt     = FPERL_FMT_D;
      end
      FPERL_OP_DMUL_Q: begin
        opnd_dbl = 1'b1;
        rfmt     = FPERL_FMT_Q;
      end
      default: begin
        opnd_dbl = (req_in.fmt == FPERL_FMT_D);
        rfmt     = opnd_dbl ? FPERL_FMT_D : FPERL_FMT_S;
      end
    endcase
  end

  fperl_unpack u_unpack_src1 (
    .src_in   (req_in.src1),
    .dbl_in   (opnd_dbl),
    .opnd_out (a)
  );

  fperl_unpack u_unpack_src2 (
    .src_in   (req_in.src2),
    .dbl_in   (opnd_dbl),
    .opnd_out (b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // special result packing

  function automatic logic [127:0] pack_special(fperl_fmt_type f, logic sign, logic inf, logic nan);
    fperl_sgl_type  s;
    fperl_dbl_type  d;
    fperl_quad_type q;
    s = {sign & ~nan, {8{inf | nan}}, {23{nan}}};
    d = {sign & ~nan, {11{inf | nan}}, {52{nan}}};
    q = {sign & ~nan, {15{inf | nan}}, {112{nan}}};
    case (f)
      FPERL_FMT_S: pack_special = {96'h0, s};
      FPERL_FMT_D: pack_special = {64'h0, d};
      default:     pack_special = q;
    endcase
  endfunction

  // quiets the NaN and zero-fills whatever low bits the result format adds
  function automatic logic [127:0] pack_nan(fperl_fmt_type f, fperl_opnd_type o);
    fperl_sgl_type  s;
    fperl_dbl_type  d;
    fperl_quad_type q;
    s = {o.sign, {8{1'b1}}, 1'b1, o.frac[50:29]};
    d = {o.sign, {11{1'b1}}, 1'b1, o.frac[50:0]};
    q = {o.sign, {15{1'b1}}, 1'b1, o.frac[50:0], 60'h0};
    case (f)
      FPERL_FMT_S: pack_nan = {96'h0, s};
      FPERL_FMT_D: pack_nan = {64'h0, d};
      default:     pack_nan = q;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // float to integer truncation

  always_comb begin
    ue    = {1'b0, b.exp} - `FPERL_EXP_BIAS;
    sig   = {(b.exp != 11'h000), b.frac, 11'h000};
    wide  = {sig, 64'h0} >> (`FPERL_I64_TOP - ue[5:0]);
    big   = !ue[11] && (ue[10:6] != 5'h00);
    if (ue[11]) begin
      trunc = 64'h0;
      lost  = !b.is_zero;
    end else begin
      trunc = wide[127:64];
      lost  = |wide[63:0];
    end
    neg   = ~trunc + 64'h1;
    inv32 = b.is_nan | b.is_inf | big | (!b.sign & |trunc[63:31])
            | (b.sign & (|trunc[63:32] | (trunc[31] & |trunc[30:0])));
    inv64 = b.is_nan | b.is_inf | big | (!b.sign & trunc[63])
            | (b.sign & trunc[63] & |trunc[62:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // result and exception selection

  // relaxed_ieee_bit is stored for software only and steers nothing here
  always_comb begin
    exc      = '0;
    res      = req_in.core_result;
    dest_wr  = 1'b1;
    cond_wr  = 1'b0;
    cond_val = `FPERL_CMP_EQ;
    eff_sub  = a.sign ^ b.sign ^ (req_in.op == FPERL_OP_SUB);
    case (req_in.op)
      FPERL_OP_ADD, FPERL_OP_SUB, FPERL_OP_MUL, FPERL_OP_DIV, FPERL_OP_SMUL_D, FPERL_OP_DMUL_Q: begin
        if (a.is_nan || b.is_nan) begin
          res = pack_nan(rfmt, a.is_nan ? a : b);
          exc[`FPERL_EXC_BAD] = a.is_snan | b.is_snan;
        end else if (((req_in.op == FPERL_OP_ADD) || (req_in.op == FPERL_OP_SUB)) && a.is_inf && b.is_inf && eff_sub) begin
          res = pack_special(rfmt, 1'b0, 1'b0, 1'b1);
          exc[`FPERL_EXC_BAD] = 1'b1;
        end else if (((req_in.op == FPERL_OP_MUL) || (req_in.op == FPERL_OP_SMUL_D) ||
                      (req_in.op == FPERL_OP_DMUL_Q)) &&
                     ((a.is_inf && b.is_zero) || (a.is_zero && b.is_inf))) begin
          res = pack_special(rfmt, 1'b0, 1'b0, 1'b1);
          exc[`FPERL_EXC_BAD] = 1'b1;
        end else if ((req_in.op == FPERL_OP_DIV) &&
                     ((a.is_inf && b.is_inf) || (a.is_zero && b.is_zero))) begin
          res = pack_special(rfmt, 1'b0, 1'b0, 1'b1);
          exc[`FPERL_EXC_BAD] = 1'b1;
        end else if ((req_in.op == FPERL_OP_DIV) && b.is_zero && !a.is_inf) begin
          res = pack_special(rfmt, a.sign ^ b.sign, 1'b1, 1'b0);
          exc[`FPERL_EXC_DZ] = 1'b1;
        end else if ((req_in.op == FPERL_OP_SMUL_D) || (req_in.op == FPERL_OP_DMUL_Q)) begin
          res = req_in.core_result;
        end else if (((req_in.op == FPERL_OP_ADD) || (req_in.op == FPERL_OP_SUB)) &&
                     req_in.core_exact_zero && eff_sub) begin
          res = pack_special(rfmt, round_mode == `FPERL_RD_MINUS, 1'b0, 1'b0);
        end else begin
          exc[`FPERL_EXC_OVF] = req_in.core_overflow;
          exc[`FPERL_EXC_INX] = req_in.core_inexact;
          // tiny flag comes from the exact value, before any rounding
          exc[`FPERL_EXC_UNF] = req_in.core_tiny &
                                (trap_mask[`FPERL_EXC_UNF] | req_in.core_inexact);
        end
      end
      FPERL_OP_SQRT: begin
        if (b.is_nan) begin
          res = pack_nan(rfmt, b);
          exc[`FPERL_EXC_BAD] = b.is_snan;
        end else if (b.sign && !b.is_zero) begin
          res = pack_special(rfmt, 1'b0, 1'b0, 1'b1);
          exc[`FPERL_EXC_BAD] = 1'b1;
        end else begin
          exc[`FPERL_EXC_INX] = req_in.core_inexact;
        end
      end
      FPERL_OP_CMP: begin
        dest_wr = 1'b0;
        cond_wr = 1'b1;
        if (a.is_nan || b.is_nan) begin
          cond_val = `FPERL_CMP_UN;
          exc[`FPERL_EXC_BAD] = a.is_snan | b.is_snan | req_in.signal_unordered;
        end else if ((a.is_zero && b.is_zero) || ({a.sign, a.exp, a.frac} == {b.sign, b.exp, b.frac})) begin
          cond_val = `FPERL_CMP_EQ;
        end else if (a.sign != b.sign) begin
          cond_val = a.sign ? `FPERL_CMP_LT : `FPERL_CMP_GT;
        end else begin
          cond_val = (({a.exp, a.frac} < {b.exp, b.frac}) ^ a.sign) ? `FPERL_CMP_LT : `FPERL_CMP_GT;
        end
      end
      FPERL_OP_TO_I32: begin
        if (inv32) begin
          exc[`FPERL_EXC_BAD] = 1'b1;
          res = {96'h0, b.sign ? `FPERL_I32_MIN : `FPERL_I32_MAX};
        end else begin
          exc[`FPERL_EXC_INX] = lost;
          res = {96'h0, b.sign ? neg[31:0] : trunc[31:0]};
        end
      end
      FPERL_OP_TO_I64: begin
        if (inv64) begin
          exc[`FPERL_EXC_BAD] = 1'b1;
          res = {64'h0, b.sign ? `FPERL_I64_MIN : `FPERL_I64_MAX};
        end else begin
          exc[`FPERL_EXC_INX] = lost;
          res = {64'h0, b.sign ? neg : trunc};
        end
      end
      default: begin
        dest_wr = 1'b0;
      end
    endcase
  end

  // one enabled exception causes the trap; invalid ranks first
  always_comb begin
    enabled   = exc & trap_mask;
    trap      = fire & (|enabled);
    trap_pick = '0;
    for (int i = 0; i < `FPERL_EXC_W; i++) begin
      if (enabled[i]) begin
        trap_pick    = '0;
        trap_pick[i] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  always_comb begin
    state_word = '0;
    state_word[`FPERL_RD_LSB +: 2]                 = round_mode;
    state_word[`FPERL_TEM_LSB +: `FPERL_EXC_W]     = trap_mask;
    state_word[`FPERL_RELAX_BIT]                   = relaxed_ieee_bit;
    state_word[`FPERL_FTT_LSB +: 3]                = trap_kind;
    state_word[`FPERL_QNE_BIT]                     = 1'b0;
    state_word[`FPERL_COND0_LSB +: `FPERL_COND_W]  = fp_cond_codes[0];
    state_word[`FPERL_AEXC_LSB +: `FPERL_EXC_W]    = accrued;
    state_word[`FPERL_CEXC_LSB +: `FPERL_EXC_W]    = current;
    cond_word = '0;
    for (int i = 1; i < 4; i++) begin
      cond_word[(i - 1) * `FPERL_COND_W +: `FPERL_COND_W] = fp_cond_codes[i];
    end
    for (int i = 0; i < 4; i++) begin
      be_mask[i * 8 +: 8] = {8{avs_byteenable_in[i]}};
    end
    wr_state = (state_word & ~be_mask) | (avs_writedata_in & be_mask);
    wr_cond  = (cond_word & ~be_mask) | (avs_writedata_in & be_mask);
  end

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~bus_ack;
  assign sw_wr_state = avs_write_in & bus_ack & (avs_address_in == `FPERL_OFS_STATE);
  assign sw_wr_cond  = avs_write_in & bus_ack & (avs_address_in == `FPERL_OFS_COND);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_ack          <= 1'b0;
      avs_readdata_out <= '0;
    end else begin
      bus_ack <= (avs_read_in | avs_write_in) & ~bus_ack;
      if (avs_read_in && !bus_ack) begin
        case (avs_address_in)
          `FPERL_OFS_STATE: avs_readdata_out <= state_word;
          `FPERL_OFS_COND:  avs_readdata_out <= cond_word;
          `FPERL_OFS_TRAPS: avs_readdata_out <= {16'h0, trap_count};
          default:          avs_readdata_out <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software control fields

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      round_mode       <= `FPERL_RD_NEAREST;
      trap_mask        <= '0;
      relaxed_ieee_bit <= 1'b0;
    end else if (sw_wr_state) begin
      round_mode       <= wr_state[`FPERL_RD_LSB +: 2];
      trap_mask        <= wr_state[`FPERL_TEM_LSB +: `FPERL_EXC_W];
      relaxed_ieee_bit <= wr_state[`FPERL_RELAX_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exception fields: hardware wins for current; accrued keeps a same-cycle software write and ORs in untrapped flags

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      current <= '0;
      accrued <= '0;
    end else begin
      if (sw_wr_state) begin
        current <= wr_state[`FPERL_CEXC_LSB +: `FPERL_EXC_W];
        accrued <= wr_state[`FPERL_AEXC_LSB +: `FPERL_EXC_W];
      end
      if (trap) begin
        current <= trap_pick;
      end else if (fire) begin
        current <= exc;
        accrued <= (sw_wr_state ? wr_state[`FPERL_AEXC_LSB +: `FPERL_EXC_W] : accrued) | exc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // condition codes

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fp_cond_codes <= '0;
    end else begin
      if (sw_wr_state) begin
        fp_cond_codes[0] <= wr_state[`FPERL_COND0_LSB +: `FPERL_COND_W];
      end
      if (sw_wr_cond) begin
        for (int i = 1; i < 4; i++) begin
          fp_cond_codes[i] <= wr_cond[(i - 1) * `FPERL_COND_W +: `FPERL_COND_W];
        end
      end
      if (fire && cond_wr && !trap) begin
        fp_cond_codes[req_in.cond_sel] <= cond_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trap type and trap counter

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trap_kind <= `FPERL_FTT_NONE;
    end else if (trap) begin
      trap_kind <= `FPERL_FTT_IEEE;
    end else if (fire || handler_entry_in) begin
      trap_kind <= `FPERL_FTT_NONE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trap_count <= '0;
    end else if (trap) begin
      trap_count <= trap_count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer to the pipeline

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_out <= '0;
    end else begin
      resp_out.valid      <= fire;
      resp_out.dest_write <= fire & dest_wr & ~trap;
      resp_out.trap       <= trap;
      resp_out.cexc       <= trap ? trap_pick : exc;
      resp_out.result     <= res;
    end
  end

endmodule
`default_nettype wire

// ===== verilog/fperl_pkg.sv
// types shared by the floating-point exception logic
`default_nettype none
package fperl_pkg;

  typedef enum logic [3:0] {
    FPERL_OP_ADD    = 4'h0,
    FPERL_OP_SUB    = 4'h1,
    FPERL_OP_MUL    = 4'h2,
    FPERL_OP_DIV    = 4'h3,
    FPERL_OP_SQRT   = 4'h4,
    FPERL_OP_CMP    = 4'h5,
    FPERL_OP_TO_I32 = 4'h6,
    FPERL_OP_TO_I64 = 4'h7,
    FPERL_OP_SMUL_D = 4'h8,
    FPERL_OP_DMUL_Q = 4'h9
  } fperl_op_type;

  typedef enum logic [1:0] {
    FPERL_FMT_S = 2'h0,
    FPERL_FMT_D = 2'h1,
    FPERL_FMT_Q = 2'h2
  } fperl_fmt_type;

  typedef struct packed {
    logic          sign;
    logic [7:0]    exp;
    logic [22:0]   frac;
  } fperl_sgl_type;

  typedef struct packed {
    logic          sign;
    logic [10:0]   exp;
    logic [51:0]   frac;
  } fperl_dbl_type;

  typedef struct packed {
    logic          sign;
    logic [14:0]   exp;
    logic [111:0]  frac;
  } fperl_quad_type;

  // operand widened to double layout plus its class
  typedef struct packed {
    logic          sign;
    logic [10:0]   exp;
    logic [51:0]   frac;
    logic          is_zero;
    logic          is_inf;
    logic          is_nan;
    logic          is_snan;
  } fperl_opnd_type;

  typedef struct packed {
    logic          valid;
    fperl_op_type  op;
    fperl_fmt_type fmt;
    logic          signal_unordered;
    logic [1:0]    cond_sel;
    logic [63:0]   src1;
    logic [63:0]   src2;
    logic [127:0]  core_result;
    logic          core_tiny;
    logic          core_inexact;
    logic          core_overflow;
    logic          core_exact_zero;
  } fperl_req_type;

  typedef struct packed {
    logic          valid;
    logic          dest_write;
    logic          trap;
    logic [4:0]    cexc;
    logic [127:0]  result;
  } fperl_resp_type;

endpackage
`default_nettype wire

// ===== verilog/fperl_unpack.sv
// operand unpacker: widens single or double to double layout and classifies it
`timescale 1ns/1ps
`default_nettype none
`include "fperl_cfg.svh"
module fperl_unpack
  import fperl_pkg::*;
(
  input  wire logic [63:0]   src_in,
  input  wire logic          dbl_in,
  output var fperl_opnd_type opnd_out
);

  fperl_sgl_type s;
  fperl_dbl_type d;

  always_comb begin
    s = src_in[31:0];
    d = src_in;
    opnd_out = '0;
    if (dbl_in) begin
      opnd_out.sign = d.sign;
      opnd_out.exp  = d.exp;
      opnd_out.frac = d.frac;
    end else begin
      opnd_out.sign = s.sign;
      // single subnormals keep exponent zero: class and tininess stay right
      if (s.exp == 8'h00) begin
        opnd_out.exp = 11'h000;
      end else if (s.exp == `FPERL_SGL_EXP_MAX) begin
        opnd_out.exp = `FPERL_DBL_EXP_MAX;
      end else begin
        opnd_out.exp = {3'h0, s.exp} + `FPERL_SGL_REBIAS;
      end
      opnd_out.frac = {s.frac, 29'h0};
    end
    opnd_out.is_zero = (opnd_out.exp == 11'h000) && (opnd_out.frac == 52'h0);
    opnd_out.is_inf  = (opnd_out.exp == `FPERL_DBL_EXP_MAX) && (opnd_out.frac == 52'h0);
    opnd_out.is_nan  = (opnd_out.exp == `FPERL_DBL_EXP_MAX) && (opnd_out.frac != 52'h0);
    opnd_out.is_snan = opnd_out.is_nan && !opnd_out.frac[51];
  end

endmodule
`default_nettype wire
